// >>> inc/gwl_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the GPIO event block
// Assumes: Byte-wide runtime register port, one byte per offset
// Notes:   Pin index is (bank - 1) * 8 + bit
`ifndef GWL_DEFINES_SVH
`define GWL_DEFINES_SVH

`define GWL_NPINS         48
`define GWL_OFS_CFG_BASE  8'h00
`define GWL_OFS_WST_BASE  8'h30
`define GWL_OFS_WEN_BASE  8'h34
`define GWL_OFS_GWEN      8'h38
`define GWL_OFS_IST_BASE  8'h39
`define GWL_OFS_IEN_BASE  8'h3C
`define GWL_OFS_MSC       8'h3F
`define GWL_OFS_DATA_BASE 8'h4B
`define GWL_OFS_LED_ONE_CONTROL      8'h5D
`define GWL_OFS_LED_TWO_CONTROL      8'h5E

`define GWL_CFG_DIR       0
`define GWL_CFG_POL       1
`define GWL_CFG_FUNC_LO   2
`define GWL_CFG_FUNC_HI   3
`define GWL_CFG_ODRAIN    7

`define GWL_CFG_RST       8'h01
`define GWL_CFG_OUT_LOW   8'h00
`define GWL_FUNC_GPIO     2'h0
`define GWL_FUNC_LED      2'h1
`define GWL_FUNC_EITHER_EDGE_INTERRUPT     2'h2

`define GWL_LED_OFF       2'h0
`define GWL_LED_ON        2'h1
`define GWL_LED_BLINK     2'h2

`define GWL_BLINK_HALF    16384

`endif

// >>> inc/gwl_pkg.sv
// Purpose: Types shared by the GPIO event block and its bench
// Assumes: Host port carries one byte access per cycle
// Notes:   Read and write strobes are one-cycle pulses
package gwl_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gwl_host_req_t;

endpackage

// >>> src/gwl_gpio_events.sv
// Purpose: GPIO pin data, wake and interrupt edge status, either-edge pins, LED control
// Assumes: Host reaches the runtime registers through a byte port on sys_clk
// Notes:   Pin, 32 kHz and main-power inputs pass two flip-flops before use
`timescale 1ns/1ns
`include "gwl_defines.svh"
`default_nettype none

module gwl_gpio_events
  import gwl_pkg::*;
#(
  parameter int BLINK_HALF = `GWL_BLINK_HALF
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire gwl_host_req_t            host_req,
  output var  logic [7:0]               host_rdata,
  input  wire logic [`GWL_NPINS-1:0]    pin_in,
  output var  logic [`GWL_NPINS-1:0]    pin_out,
  output var  logic [`GWL_NPINS-1:0]    pin_oe,
  input  wire logic [`GWL_NPINS-1:0]    alt_out,
  input  wire logic [`GWL_NPINS-1:0]    alt_oe,
  input  wire logic [1:0]               tach_event,
  input  wire logic                     clk_32k,
  input  wire logic                     main_power_ok,
  output var  logic                     wake_event,
  output var  logic                     intr_event
);

  localparam int NP = `GWL_NPINS;

  function automatic logic either_edge_interrupt_capable(input int p);
    return (p == 9) || (p == 10) || (p == 25) || (p == 27) || (p == 40) || (p == 41);
  endfunction

  function automatic logic reverts_low(input int p);
    return (p == 18) || (p == 19) || (p == 35);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [NP-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [1:0]    aux1_reg, aux2_reg;
  logic [2:0]    arm_reg;
  logic          clk32_prev_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_reg      <= '0;
      sync2_reg      <= '0;
      prev_reg       <= '0;
      aux1_reg       <= '0;
      aux2_reg       <= '0;
      clk32_prev_reg <= 1'b0;
      arm_reg        <= '0;
    end else begin
      sync1_reg      <= pin_in;
      sync2_reg      <= sync1_reg;
      prev_reg       <= sync2_reg;
      aux1_reg       <= {main_power_ok, clk_32k};
      aux2_reg       <= aux1_reg;
      clk32_prev_reg <= aux2_reg[0];
      // Holds off edge events until the synchronisers are filled
      arm_reg        <= {arm_reg[1:0], 1'b1};
    end
  end

  logic vcc_ok;
  logic tick32;
  assign vcc_ok = aux2_reg[1];
  assign tick32 = aux2_reg[0] & ~clk32_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, data and enable registers
  logic [7:0] cfg_reg [NP];
  logic [7:0] cfg_next [NP];
  logic [7:0] data_reg [6];
  logic [7:0] data_next [6];
  logic [7:0] wen_reg [4];
  logic [7:0] wen_next [4];
  logic [7:0] ien_reg [3];
  logic [7:0] ien_next [3];
  logic [7:0] led_reg [2];
  logic [7:0] led_next [2];
  logic       gwen_reg, gwen_next;

  logic [NP-1:0] pol, is_gpio_in, is_gpio_out, either_edge_interrupt_sel, odrain, dout;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pol[p]         = cfg_reg[p][`GWL_CFG_POL];
      odrain[p]      = cfg_reg[p][`GWL_CFG_ODRAIN];
      either_edge_interrupt_sel[p]    = either_edge_interrupt_capable(p) &&
                       cfg_reg[p][`GWL_CFG_FUNC_HI:`GWL_CFG_FUNC_LO] == `GWL_FUNC_EITHER_EDGE_INTERRUPT;
      is_gpio_in[p]  = cfg_reg[p][`GWL_CFG_FUNC_HI:`GWL_CFG_FUNC_LO] == `GWL_FUNC_GPIO &&
                       cfg_reg[p][`GWL_CFG_DIR];
      is_gpio_out[p] = cfg_reg[p][`GWL_CFG_FUNC_HI:`GWL_CFG_FUNC_LO] == `GWL_FUNC_GPIO &&
                       !cfg_reg[p][`GWL_CFG_DIR];
      dout[p]        = data_reg[p / 8][p % 8];
    end
  end

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      cfg_next[p] = cfg_reg[p];
      if (host_req.wr && host_req.addr == `GWL_OFS_CFG_BASE + 8'(p)) begin
        cfg_next[p] = host_req.wdata;
      end
      if (reverts_low(p) && !vcc_ok) begin
        cfg_next[p] = `GWL_CFG_OUT_LOW;
      end
    end
    for (int b = 0; b < 6; b++) begin
      data_next[b] = data_reg[b];
      if (host_req.wr && host_req.addr == `GWL_OFS_DATA_BASE + 8'(b)) begin
        for (int i = 0; i < 8; i++) begin
          if (is_gpio_out[b * 8 + i]) begin
            data_next[b][i] = host_req.wdata[i];
          end
        end
      end
    end
    for (int r = 0; r < 4; r++) begin
      wen_next[r] = wen_reg[r];
      if (host_req.wr && host_req.addr == `GWL_OFS_WEN_BASE + 8'(r)) begin
        wen_next[r] = host_req.wdata;
      end
    end
    for (int r = 0; r < 3; r++) begin
      ien_next[r] = ien_reg[r];
      if (host_req.wr && host_req.addr == `GWL_OFS_IEN_BASE + 8'(r)) begin
        ien_next[r] = host_req.wdata;
      end
    end
    for (int l = 0; l < 2; l++) begin
      led_next[l] = led_reg[l];
      if (host_req.wr && host_req.addr == (l == 0 ? `GWL_OFS_LED_ONE_CONTROL : `GWL_OFS_LED_TWO_CONTROL)) begin
        led_next[l] = host_req.wdata;
      end
    end
    gwen_next = gwen_reg;
    if (host_req.wr && host_req.addr == `GWL_OFS_GWEN) begin
      gwen_next = host_req.wdata[0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < NP; p++) begin
        cfg_reg[p] <= reverts_low(p) ? `GWL_CFG_OUT_LOW : `GWL_CFG_RST;
      end
      for (int b = 0; b < 6; b++) data_reg[b] <= 8'h00;
      for (int r = 0; r < 4; r++) wen_reg[r] <= 8'h00;
      for (int r = 0; r < 3; r++) ien_reg[r] <= 8'h00;
      led_reg[0] <= 8'h00;
      led_reg[1] <= 8'h00;
      gwen_reg   <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      data_reg <= data_next;
      wen_reg  <= wen_next;
      ien_reg  <= ien_next;
      led_reg  <= led_next;
      gwen_reg <= gwen_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge events and sticky status
  logic [NP-1:0] ev;
  logic [7:0]    wev [4];
  logic [7:0]    iev [3];
  logic [7:0]    mev;
  logic [7:0]    wst_reg [4];
  logic [7:0]    wst_next [4];
  logic [7:0]    ist_reg [3];
  logic [7:0]    ist_next [3];
  logic [7:0]    msc_reg, msc_next;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      if (either_edge_interrupt_sel[p]) begin
        ev[p] = sync2_reg[p] != prev_reg[p];
      end else begin
        ev[p] = (sync2_reg[p] ^ pol[p]) & ~(prev_reg[p] ^ pol[p]);
      end
      ev[p] = ev[p] & arm_reg[2] & (!cfg_reg[p][`GWL_CFG_DIR] ? either_edge_interrupt_sel[p] : 1'b1);
    end
    wev[0] = ev[7:0];
    wev[1] = {ev[15:12], 1'b0, ev[10:8]};
    wev[2] = {ev[41], ev[40], ev[27], ev[25], ev[19:16]};
    wev[3] = ev[39:32];
    iev[0] = {ev[40], ev[14:12], 1'b0, ev[10:8]};
    iev[1] = {ev[41], ev[27], ev[26], ev[25], ev[19:16]};
    iev[2] = {ev[39:36], 2'b00, tach_event};
    mev    = {2'b00, ev[41], ev[40], ev[27], ev[25], ev[10], ev[9]};
  end

  always_comb begin
    for (int r = 0; r < 4; r++) begin
      wst_next[r] = wst_reg[r];
      if (host_req.wr && host_req.addr == `GWL_OFS_WST_BASE + 8'(r)) begin
        wst_next[r] = wst_reg[r] & ~host_req.wdata;
      end
      wst_next[r] = wst_next[r] | wev[r];
    end
    for (int r = 0; r < 3; r++) begin
      ist_next[r] = ist_reg[r];
      if (host_req.wr && host_req.addr == `GWL_OFS_IST_BASE + 8'(r)) begin
        ist_next[r] = ist_reg[r] & ~host_req.wdata;
      end
      ist_next[r] = ist_next[r] | iev[r];
    end
    msc_next = msc_reg;
    if (host_req.wr && host_req.addr == `GWL_OFS_MSC) begin
      msc_next = msc_reg & ~host_req.wdata;
    end
    msc_next = msc_next | mev;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int r = 0; r < 4; r++) wst_reg[r] <= 8'h00;
      for (int r = 0; r < 3; r++) ist_reg[r] <= 8'h00;
      msc_reg <= 8'h00;
    end else begin
      wst_reg <= wst_next;
      ist_reg <= ist_next;
      msc_reg <= msc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs; either-edge pins count only with the mode selected
  logic [7:0] wgate [4];
  logic [7:0] igate [3];
  logic       wake_next, intr_next;

  always_comb begin
    wgate[0] = 8'hFF;
    wgate[1] = {5'h1F, ~either_edge_interrupt_capable(10) | either_edge_interrupt_sel[10], ~either_edge_interrupt_capable(9) | either_edge_interrupt_sel[9], 1'b1};
    wgate[2] = {either_edge_interrupt_sel[41], either_edge_interrupt_sel[40], either_edge_interrupt_sel[27], either_edge_interrupt_sel[25], 4'hF};
    wgate[3] = 8'hFF;
    igate[0] = {either_edge_interrupt_sel[40], 4'hF, either_edge_interrupt_sel[10], either_edge_interrupt_sel[9], 1'b1};
    igate[1] = {either_edge_interrupt_sel[41], either_edge_interrupt_sel[27], 1'b1, either_edge_interrupt_sel[25], 4'hF};
    igate[2] = 8'hFF;
    wake_next = 1'b0;
    intr_next = 1'b0;
    for (int r = 0; r < 4; r++) begin
      wake_next = wake_next | (|(wst_reg[r] & wen_reg[r] & wgate[r]));
    end
    for (int r = 0; r < 3; r++) begin
      intr_next = intr_next | (|(ist_reg[r] & ien_reg[r] & igate[r]));
    end
    wake_next = wake_next & gwen_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED blink timing from the 32 kHz clock
  logic [15:0] blink_cnt_reg, blink_cnt_next;
  logic        blink_reg, blink_next;

  always_comb begin
    blink_cnt_next = blink_cnt_reg;
    blink_next     = blink_reg;
    if (tick32) begin
      if (blink_cnt_reg == 16'(BLINK_HALF - 1)) begin
        blink_cnt_next = 16'h0000;
        blink_next     = ~blink_reg;
      end else begin
        blink_cnt_next = blink_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      blink_cnt_reg <= 16'h0000;
      blink_reg     <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and host read data
  logic [NP-1:0] out_next, oe_next;
  logic [7:0]    rdata_next;
  logic          led_on;

  always_comb begin
    led_on = 1'b0;
    for (int p = 0; p < NP; p++) begin
      out_next[p] = dout[p] ^ pol[p];
      oe_next[p]  = odrain[p] ? ~out_next[p] : 1'b1;
      if (either_edge_interrupt_sel[p] || is_gpio_in[p]) begin
        out_next[p] = 1'b0;
        oe_next[p]  = 1'b0;
      end else if (!is_gpio_out[p]) begin
        out_next[p] = alt_out[p] ^ pol[p];
        oe_next[p]  = alt_oe[p];
        if (p >= 40 && cfg_reg[p][`GWL_CFG_FUNC_HI:`GWL_CFG_FUNC_LO] == `GWL_FUNC_LED) begin
          led_on = led_reg[p - 40][1:0] == `GWL_LED_ON ||
                   (led_reg[p - 40][1:0] == `GWL_LED_BLINK && blink_reg);
          out_next[p] = odrain[p] ? 1'b0 : led_on;
          oe_next[p]  = odrain[p] ? led_on : 1'b1;
        end
      end
    end
    rdata_next = 8'h00;
    for (int p = 0; p < NP; p++) begin
      if (host_req.addr == `GWL_OFS_CFG_BASE + 8'(p)) rdata_next = cfg_reg[p];
    end
    for (int b = 0; b < 6; b++) begin
      if (host_req.addr == `GWL_OFS_DATA_BASE + 8'(b)) begin
        for (int i = 0; i < 8; i++) begin
          rdata_next[i] = is_gpio_out[b * 8 + i] ? dout[b * 8 + i]
                          : sync2_reg[b * 8 + i] ^ pol[b * 8 + i];
        end
      end
    end
    for (int r = 0; r < 4; r++) begin
      if (host_req.addr == `GWL_OFS_WST_BASE + 8'(r)) rdata_next = wst_reg[r];
      if (host_req.addr == `GWL_OFS_WEN_BASE + 8'(r)) rdata_next = wen_reg[r];
    end
    for (int r = 0; r < 3; r++) begin
      if (host_req.addr == `GWL_OFS_IST_BASE + 8'(r)) rdata_next = ist_reg[r];
      if (host_req.addr == `GWL_OFS_IEN_BASE + 8'(r)) rdata_next = ien_reg[r];
    end
    if (host_req.addr == `GWL_OFS_GWEN) rdata_next = {7'h00, gwen_reg};
    if (host_req.addr == `GWL_OFS_MSC)  rdata_next = msc_reg;
    if (host_req.addr == `GWL_OFS_LED_ONE_CONTROL) rdata_next = led_reg[0];
    if (host_req.addr == `GWL_OFS_LED_TWO_CONTROL) rdata_next = led_reg[1];
    if (!host_req.rd) rdata_next = host_rdata;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      host_rdata <= 8'h00;
      wake_event <= 1'b0;
      intr_event <= 1'b0;
    end else begin
      pin_out    <= out_next;
      pin_oe     <= oe_next;
      host_rdata <= rdata_next;
      wake_event <= wake_next;
      intr_event <= intr_next;
    end
  end

endmodule

`default_nettype wire

// >>> tb/gwl_gpio_events_sva.sv
// Purpose: Port assertions for the GPIO event block
// Assumes: Offsets and pin count from gwl_defines.svh
// Notes:   Bound to every instance of gwl_gpio_events
`timescale 1ns/1ns
`include "gwl_defines.svh"
`default_nettype none
module gwl_gpio_events_sva
  import gwl_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire gwl_host_req_t         host_req,
  input wire logic [7:0]            host_rdata,
  input wire logic [`GWL_NPINS-1:0] pin_out,
  input wire logic [`GWL_NPINS-1:0] pin_oe,
  input wire logic                  main_power_ok,
  input wire logic                  wake_event,
  input wire logic                  intr_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  property p_quiet;
    $fell(reset) |-> !wake_event && !intr_event;
  endproperty
  a_quiet: assert property (p_quiet) else $error("event output after reset");
  property p_low_out;
    $fell(reset) |-> ##2 (pin_oe[18] && pin_oe[19] && pin_oe[35] &&
                          !pin_out[18] && !pin_out[19] && !pin_out[35]);
  endproperty
  a_low_out: assert property (p_low_out) else $error("pins not driving low");
  property p_nopwr;
    !main_power_ok [*6] |-> pin_oe[18] && pin_oe[19] && pin_oe[35];
  endproperty
  a_nopwr: assert property (p_nopwr) else $error("pins not outputs without power");
  property p_hold;
    !$past(host_req.rd) |-> $stable(host_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_unmap;
    host_req.rd && host_req.addr > `GWL_OFS_LED_TWO_CONTROL |=> host_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_gwen;
    host_req.wr && host_req.addr == `GWL_OFS_GWEN && !host_req.wdata[0] |-> ##2 !wake_event;
  endproperty
  a_gwen: assert property (p_gwen) else $error("wake event without global enable");
  property p_w3gap;
    host_req.rd && host_req.addr == 8'h31 |=> !host_rdata[3];
  endproperty
  a_w3gap: assert property (p_w3gap) else $error("wake status 3 bit 3 set");
  property p_i3gap;
    host_req.rd && host_req.addr == `GWL_OFS_IST_BASE |=> !host_rdata[3];
  endproperty
  a_i3gap: assert property (p_i3gap) else $error("intr status 3 bit 3 set");
  property p_mscgap;
    host_req.rd && host_req.addr == `GWL_OFS_MSC |=> host_rdata[7:6] == 2'h0;
  endproperty
  a_mscgap: assert property (p_mscgap) else $error("misc status top bits set");
endmodule
bind gwl_gpio_events gwl_gpio_events_sva u_gwl_gpio_events_sva (.sys_clk(sys_clk),
  .reset(reset), .host_req(host_req), .host_rdata(host_rdata), .pin_out(pin_out),
  .pin_oe(pin_oe), .main_power_ok(main_power_ok), .wake_event(wake_event),
  .intr_event(intr_event));
`default_nettype wire

// >>> tb/test_gwl_gpio_events.sv
// Purpose: Self-checking bench for the GPIO event block
// Assumes: Short blink half period of 2 ticks
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module test_gwl_gpio_events;
  import gwl_pkg::*;
  logic          sys_clk = 1'b0;
  logic          reset = 1'b1;
  gwl_host_req_t rq = '0;
  logic [47:0]   pin_in = 48'h0;
  logic [1:0]    tach = 2'h0;
  logic          clk_32k = 1'b0;
  logic          main_power_ok = 1'b1;
  logic          run32 = 1'b0;
  logic [47:0]   alt_o = 48'h0;
  logic [47:0]   alt_e = 48'h0;
  logic [7:0]    host_rdata;
  logic [47:0]   pin_out;
  logic [47:0]   pin_oe;
  logic          wake_event;
  logic          intr_event;
  logic [7:0]    d;
  int            n_fail = 0;
  int            compares = 0;
  gwl_gpio_events #(.BLINK_HALF(2)) u_gwl_gpio_events (.sys_clk(sys_clk), .reset(reset),
    .host_req(rq), .host_rdata(host_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_out(alt_o), .alt_oe(alt_e), .tach_event(tach),
    .clk_32k(clk_32k), .main_power_ok(main_power_ok), .wake_event(wake_event),
    .intr_event(intr_event));
  initial forever #4 sys_clk = ~sys_clk;
  always begin
    @(negedge sys_clk);
    if (run32) begin
      repeat (3) @(negedge sys_clk);
      clk_32k = ~clk_32k;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    rq.wr = 1'b1;
    rq.addr = a;
    rq.wdata = v;
    @(negedge sys_clk);
    rq.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    rq.rd = 1'b1;
    rq.addr = a;
    @(negedge sys_clk);
    rq.rd = 1'b0;
    @(negedge sys_clk);
    d = host_rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("oe_low_pins", 8'h07, {5'h0, pin_oe[18], pin_oe[19], pin_oe[35]});
    chk("out_low_pins", 8'h00, {5'h0, pin_out[18], pin_out[19], pin_out[35]});
    rd(8'h12); chk("cfg18", 8'h00, d);
    rd(8'h1B); chk("cfg27", 8'h01, d);
    rd(8'h00); chk("cfg0", 8'h01, d);
    rd(8'hA0); chk("unmapped", 8'h00, d);
  endtask
  task automatic t_input;
    pin_in[0] = 1'b1;
    w(6);
    rd(8'h4B); chk("in_plain", 8'h01, d & 8'h01);
    wr(8'h00, 8'h03);
    rd(8'h4B); chk("in_inv", 8'h00, d & 8'h01);
    wr(8'h4B, 8'hFF);
    w(2);
    chk("in_oe", 8'h00, {7'h0, pin_oe[0]});
  endtask
  task automatic t_output;
    wr(8'h00, 8'h00);
    rd(8'h4B); chk("stored_kept", 8'h00, d & 8'h01);
    wr(8'h30, 8'hFF);
    wr(8'h4B, 8'h01);
    w(2);
    chk("out_drive", 8'h03, {6'h0, pin_oe[0], pin_out[0]});
    wr(8'h00, 8'h02);
    w(2);
    chk("out_inv", 8'h00, {7'h0, pin_out[0]});
    wr(8'h00, 8'h80);
    w(2);
    chk("out_odrain", 8'h01, {6'h0, pin_oe[0], pin_out[0]});
    pin_in[0] = 1'b0;
    w(6);
    pin_in[0] = 1'b1;
    w(6);
    rd(8'h4B); chk("out_read", 8'h01, d & 8'h01);
    rd(8'h30); chk("out_no_evt", 8'h00, d & 8'h01);
  endtask
  task automatic t_wake;
    wr(8'h34, 8'h02);
    wr(8'h38, 8'h01);
    pin_in[1] = 1'b1;
    w(6);
    rd(8'h30); chk("wst_rise", 8'h02, d & 8'h02);
    chk("wake_on", 8'h01, {7'h0, wake_event});
    wr(8'h30, 8'h00);
    rd(8'h30); chk("wst_w0", 8'h02, d & 8'h02);
    wr(8'h38, 8'h00);
    w(3);
    chk("wake_gated", 8'h00, {7'h0, wake_event});
    wr(8'h30, 8'h02);
    rd(8'h30); chk("wst_w1", 8'h00, d & 8'h02);
    wr(8'h02, 8'h03);
    w(6);
    wr(8'h30, 8'h04);
    pin_in[2] = 1'b1;
    w(6);
    rd(8'h30); chk("wst_pol_rise", 8'h00, d & 8'h04);
    pin_in[2] = 1'b0;
    w(6);
    rd(8'h30); chk("wst_pol_fall", 8'h04, d & 8'h04);
    wr(8'h38, 8'h01);
    w(3);
    chk("wake_pin_gated", 8'h00, {7'h0, wake_event});
    wr(8'h34, 8'h04);
    w(3);
    chk("wake_pin_on", 8'h01, {7'h0, wake_event});
    wr(8'h38, 8'h00);
  endtask
  task automatic t_either_edge_interrupt;
    wr(8'h09, 8'h09);
    wr(8'h31, 8'hFF);
    wr(8'h39, 8'hFF);
    wr(8'h3F, 8'hFF);
    pin_in[9] = 1'b1;
    w(6);
    rd(8'h3F); chk("msc_rise", 8'h01, d);
    rd(8'h31); chk("w3_rise", 8'h02, d & 8'h02);
    rd(8'h39); chk("i3_rise", 8'h02, d & 8'h02);
    wr(8'h3F, 8'h01);
    rd(8'h3F); chk("msc_clr", 8'h00, d);
    pin_in[9] = 1'b0;
    w(6);
    rd(8'h3F); chk("msc_fall", 8'h01, d);
    wr(8'h3C, 8'h02);
    w(3);
    chk("intr_on", 8'h01, {7'h0, intr_event});
    wr(8'h09, 8'h0A);
    w(3);
    chk("either_edge_interrupt_no_drive", 8'h00, {7'h0, pin_oe[9]});
    rd(8'h4C); chk("either_edge_interrupt_rd_inv", 8'h02, d & 8'h02);
    wr(8'h09, 8'h01);
    w(3);
    chk("intr_mode_off", 8'h00, {7'h0, intr_event});
    rd(8'h39); chk("i3_kept", 8'h02, d & 8'h02);
  endtask
  task automatic t_tach;
    wr(8'h3E, 8'h01);
    @(negedge sys_clk);
    tach[0] = 1'b1;
    @(negedge sys_clk);
    tach[0] = 1'b0;
    w(3);
    rd(8'h3B); chk("i5_tach", 8'h01, d & 8'h03);
    chk("intr_tach", 8'h01, {7'h0, intr_event});
    wr(8'h3B, 8'h01);
    w(3);
    chk("intr_clr", 8'h00, {7'h0, intr_event});
  endtask
  task automatic t_alt;
    wr(8'h0B, 8'h0C);
    alt_o[11] = 1'b1;
    alt_e[11] = 1'b1;
    w(3);
    chk("alt_drive", 8'h03, {6'h0, pin_oe[11], pin_out[11]});
    alt_e[11] = 1'b0;
    pin_in[11] = 1'b1;
    w(6);
    chk("alt_release", 8'h01, {6'h0, pin_oe[11], pin_out[11]});
    rd(8'h4C); chk("alt_in", 8'h08, d & 8'h08);
  endtask
  task automatic t_power;
    wr(8'h12, 8'h01);
    w(3);
    chk("oe18_in", 8'h00, {7'h0, pin_oe[18]});
    main_power_ok = 1'b0;
    w(8);
    chk("oe18_nopwr", 8'h01, {7'h0, pin_oe[18]});
    main_power_ok = 1'b1;
  endtask
  task automatic t_led;
    int n;
    logic p;
    wr(8'h28, 8'h04);
    wr(8'h29, 8'h04);
    wr(8'h5D, 8'h01);
    wr(8'h5E, 8'h00);
    w(3);
    chk("led_a", 8'h05, {5'h0, pin_oe[40], pin_out[41], pin_out[40]});
    wr(8'h5D, 8'h00);
    wr(8'h5E, 8'h01);
    w(3);
    chk("led_b", 8'h02, {6'h0, pin_out[41], pin_out[40]});
    main_power_ok = 1'b0;
    wr(8'h5D, 8'h02);
    run32 = 1'b1;
    n = 0;
    p = pin_out[40];
    repeat (200) begin
      @(negedge sys_clk);
      if (pin_out[40] !== p) n++;
      p = pin_out[40];
    end
    chk("blink", 8'h01, {7'h0, n > 3});
    run32 = 1'b0;
    w(10);
    n = 0;
    p = pin_out[40];
    repeat (100) begin
      @(negedge sys_clk);
      if (pin_out[40] !== p) n++;
      p = pin_out[40];
    end
    chk("no_clk", 8'h00, 8'(n));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    w(2);
    reset = 1'b0;
    w(3);
    t_reset;
    t_input;
    t_output;
    t_wake;
    t_either_edge_interrupt;
    t_tach;
    t_alt;
    t_power;
    t_led;
    test_done;
  end
endmodule
`default_nettype wire
